// ---- wdrs_pkg.sv ----
// Purpose: constants and types for the watchdog and reset-cause block
// Assumes: 32-bit AXI4-Lite register access, one word per register
// Notes:   oscillator counts are in oscillator cycles, others in aclk
package wdrs_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int         ADDR_W       = 8;
	localparam logic [7:0] OFS_CAUSE    = 8'h00;
	localparam logic [7:0] OFS_CTRL     = 8'h04;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFS_IRQ_CLR  = 8'h0c;
	localparam logic [7:0] OFS_IRQ_EN   = 8'h10;
	localparam logic [7:0] OFS_COUNT    = 8'h14;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int BIT_SCAN     = 4;
	localparam int BIT_WDOG     = 3;
	localparam int BIT_BROWNOUT = 2;
	localparam int BIT_EXT      = 1;
	localparam int BIT_POR      = 0;
	localparam int IRQ_EXPIRE   = 0;
	localparam int IRQ_OFF      = 1;
	localparam int IRQ_W        = 2;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0]       RST_CAUSE = 8'h01;
	localparam logic [7:0]       RST_CTRL  = 8'h00;
	localparam logic [IRQ_W-1:0] RST_IRQ   = 2'h0;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int         CLK_HZ            = 20_000_000;
	localparam int         OSC_HZ            = 1_000_000;
	localparam int         TIMEOUT_BASE_CYC  = 16384;
	localparam int         CNT_W             = 22;
	localparam int         STARTUP_DELAY_CYC = 64;
	localparam logic [2:0] TOE_CYC           = 3'h4;
	// ------------------------------------------------------------
	// bus answers
	// ------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_RUN   = 4'b0001,
		ST_PULSE = 4'b0010,
		ST_SRC   = 4'b0100,
		ST_DELAY = 4'b1000
	} wdrs_state_t;
	typedef struct packed {
		logic scan;
		logic brownout;
		logic ext;
		logic por;
	} wdrs_src_t;
	typedef struct packed {
		logic [2:0] rsvd;
		logic       wdog_turnoff_enable;
		logic       wdog_enable_bit;
		logic [2:0] wdog_period_sel;
	} wdrs_ctrl_t;
endpackage

// ---- wdrs_top.sv ----
// Purpose: watchdog timer with reset sequencing and reset-cause flags
// Assumes: oscillator pin and reset sources are asynchronous to aclk
// Notes:   aresetn acts as power-on for the block
//
// Notes on behaviour
// R1 - expiry gives an internal reset pulse of exactly one clock cycle
// R2 - delay counter starts when pulse falls; internal reset held until done
// R3 - watchdog counter advances on ticks of the separate 1MHz oscillator
// R4 - counter zeroed on restart, on disable, and during any chip reset
// R5 - enabled watchdog expiring without restart resets the chip
// R6 - period codes 0..7 select 16K up to 2048K oscillator cycles
// R7 - turn-off enable bit clears itself four cycles after being set
// R8 - writing enable one enables; zero disables only when turn-off is set
// R9 - clearing enable while turn-off is zero is ignored
// R10 - software writes both bits, then enable zero within four cycles
// R11 - control bits 7:5 always read zero
// R12 - scan reset flag set by scan reset; cleared by power-on or write 0
// R13 - watchdog flag set by watchdog reset; cleared by power-on or write 0
// R14 - brown-out flag set by brown-out; cleared by power-on or write 0
// R15 - external flag set by pin reset; cleared by power-on or write 0
// R16 - power-on flag set by power-on; cleared only by writing zero
// R17 - software should read then clear the cause flags early
// R18 - writing one to a cause flag leaves it unchanged
`timescale 1ns/1ps
module wdrs_top
	import wdrs_pkg::*;
#(
	parameter int TIMEOUT_BASE = TIMEOUT_BASE_CYC,
	parameter int STARTUP_CYC  = STARTUP_DELAY_CYC
) (
	// clock and reset
	input  logic              aclk,
	input  logic              aresetn,
	// write address
	input  logic              awvalid,
	output logic              awready,
	input  logic [ADDR_W-1:0] awaddr,
	// write data
	input  logic              wvalid,
	output logic              wready,
	input  logic [31:0]       wdata,
	input  logic [3:0]        wstrb,
	// write response
	output logic              bvalid,
	input  logic              bready,
	output logic [1:0]        bresp,
	// read address
	input  logic              arvalid,
	output logic              arready,
	input  logic [ADDR_W-1:0] araddr,
	// read data
	output logic              rvalid,
	input  logic              rready,
	output logic [31:0]       rdata,
	output logic [1:0]        rresp,
	// core and oscillator
	input  logic              wdog_restart,
	input  logic              wdog_osc,
	// reset sources, asynchronous
	input  wdrs_src_t         reset_src,
	// reset outputs and interrupt
	output logic              wdog_reset_pulse,
	output logic              chip_reset,
	output logic              irq
);
	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	localparam int DLY_W = $clog2(STARTUP_CYC + 1);

	function automatic logic reg_hit(
		input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] ofs
	);
		return a[ADDR_W-1:2] == ofs[ADDR_W-1:2];
	endfunction

	function automatic logic [CNT_W-1:0] last_count(
		input logic [2:0] sel
	);
		return CNT_W'((TIMEOUT_BASE << sel) - 1);
	endfunction

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [2:0]        osc_sync_reg;
	wdrs_src_t         src_s1_reg;
	wdrs_src_t         src_s2_reg;
	wdrs_state_t       state_reg;
	wdrs_state_t       state_next;
	logic [DLY_W-1:0]  delay_reg;
	logic [CNT_W-1:0]  wcnt_reg;
	wdrs_ctrl_t        ctrl_reg;
	logic [2:0]        toe_cnt_reg;
	logic [7:0]        cause_reg;
	logic [IRQ_W-1:0]  irq_stat_reg;
	logic [IRQ_W-1:0]  irq_en_reg;
	logic              irq_reg;
	logic              pulse_reg;
	logic              chip_rst_reg;
	logic              awready_reg;
	logic              wready_reg;
	logic              aw_hold_reg;
	logic              w_hold_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [31:0]       wdata_reg;
	logic [3:0]        wstrb_reg;
	logic              bvalid_reg;
	logic [1:0]        bresp_reg;
	logic              arready_reg;
	logic              rvalid_reg;
	logic [31:0]       rdata_reg;
	logic [1:0]        rresp_reg;

	// ------------------------------------------------------------
	// decode and datapath wires
	// ------------------------------------------------------------
	wire              tick     = osc_sync_reg[1] & ~osc_sync_reg[2];
	wire              src_any  = |src_s2_reg;
	wire              in_reset = state_reg != ST_RUN;
	wire              aw_fire  = awvalid & awready_reg;
	wire              w_fire   = wvalid & wready_reg;
	wire              b_fire   = bvalid_reg & bready;
	wire              ar_fire  = arvalid & arready_reg;
	wire              r_fire   = rvalid_reg & rready;
	wire              wr_go    = aw_hold_reg & w_hold_reg & ~bvalid_reg;
	wire              wr_lane  = wr_go & wstrb_reg[0];
	wire wdrs_ctrl_t  wd_ctrl  = wdrs_ctrl_t'(wdata_reg[7:0]);
	wire [7:0]        wd_byte  = wdata_reg[7:0];

	wire hit_cause = reg_hit(awaddr_reg, OFS_CAUSE);
	wire hit_ctrl  = reg_hit(awaddr_reg, OFS_CTRL);
	wire hit_iclr  = reg_hit(awaddr_reg, OFS_IRQ_CLR);
	wire hit_ien   = reg_hit(awaddr_reg, OFS_IRQ_EN);
	wire hit_istat = reg_hit(awaddr_reg, OFS_IRQ_STAT);
	wire hit_cnt   = reg_hit(awaddr_reg, OFS_COUNT);
	wire wr_hit    = hit_cause | hit_ctrl | hit_iclr | hit_ien |
	                 hit_istat | hit_cnt;

	wire wr_cause  = wr_lane & hit_cause;
	wire wr_ctrl   = wr_lane & hit_ctrl;
	wire wr_iclr   = wr_lane & hit_iclr;
	wire wr_ien    = wr_lane & hit_ien;

	// watchdog counter control
	wire wcnt_clr  = in_reset | wdog_restart |
	                 ~ctrl_reg.wdog_enable_bit; // R4
	wire at_last   = wcnt_reg == last_count(ctrl_reg.wdog_period_sel); // R6
	wire expire    = tick & at_last & ~wcnt_clr; // R5

	// enable bit: set by one, cleared only under turn-off
	wire en_write  = wd_ctrl.wdog_enable_bit ? 1'b1 :
	                 ctrl_reg.wdog_turnoff_enable ? 1'b0 :
	                 ctrl_reg.wdog_enable_bit; // R8 R9
	wire off_evt   = wr_ctrl & ctrl_reg.wdog_enable_bit & ~en_write;
	wire toe_set   = wr_ctrl & wd_ctrl.wdog_turnoff_enable;
	wire toe_end   = toe_cnt_reg == 3'h1;

	// cause flags: write zero clears, write one keeps, set wins
	wire [7:0] cause_kept = wr_cause ? (cause_reg & wd_byte) :
	                        cause_reg; // R18
	wire [7:0] cause_set  = {3'h0, src_s2_reg.scan, expire,
	                         src_s2_reg.brownout, src_s2_reg.ext,
	                         1'b0}; // R12 R13 R14 R15
	wire [7:0] cause_next = src_s2_reg.por ? RST_CAUSE :
	                        ((cause_kept | cause_set) & 8'h1f); // R16

	// interrupt status
	wire [IRQ_W-1:0] irq_evt  = {off_evt, expire};
	wire [IRQ_W-1:0] irq_clr  = wr_iclr ? wd_byte[IRQ_W-1:0] : RST_IRQ;
	wire [IRQ_W-1:0] istat_nx = (irq_stat_reg & ~irq_clr) | irq_evt;
	wire [IRQ_W-1:0] ien_nx   = wr_ien ? wd_byte[IRQ_W-1:0] :
	                            irq_en_reg;

	// read decode
	wire rd_cause = reg_hit(araddr, OFS_CAUSE);
	wire rd_ctrl  = reg_hit(araddr, OFS_CTRL);
	wire rd_istat = reg_hit(araddr, OFS_IRQ_STAT);
	wire rd_iclr  = reg_hit(araddr, OFS_IRQ_CLR);
	wire rd_ien   = reg_hit(araddr, OFS_IRQ_EN);
	wire rd_cnt   = reg_hit(araddr, OFS_COUNT);
	wire rd_hit   = rd_cause | rd_ctrl | rd_istat | rd_iclr |
	                rd_ien | rd_cnt;
	wire [31:0] rd_data =
		rd_cause ? {24'h0, cause_reg} :
		rd_ctrl  ? {24'h0, 3'h0, ctrl_reg[4:0]} : // R11
		rd_istat ? {30'h0, irq_stat_reg} :
		rd_ien   ? {30'h0, irq_en_reg} :
		rd_cnt   ? {{(32 - CNT_W){1'b0}}, wcnt_reg} :
		32'h0;

	// ------------------------------------------------------------
	// synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_sync_reg <= 3'h0;
		end else begin
			osc_sync_reg <= {osc_sync_reg[1:0], wdog_osc}; // R3
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_s1_reg <= '0;
			src_s2_reg <= '0;
		end else begin
			src_s1_reg <= reset_src;
			src_s2_reg <= src_s1_reg;
		end
	end

	// ------------------------------------------------------------
	// reset sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_RUN: begin
				if (src_any) begin
					state_next = ST_SRC;
				end else if (expire) begin
					state_next = ST_PULSE; // R5
				end
			end
			ST_PULSE: begin
				state_next = src_any ? ST_SRC : ST_DELAY; // R1
			end
			ST_SRC: begin
				if (!src_any) begin
					state_next = ST_DELAY;
				end
			end
			ST_DELAY: begin
				if (src_any) begin
					state_next = ST_SRC;
				end else if (delay_reg == '0) begin
					state_next = ST_RUN; // R2
				end
			end
			default: begin
				state_next = ST_SRC;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg    <= ST_RUN;
			pulse_reg    <= 1'b0;
			chip_rst_reg <= 1'b0;
		end else begin
			state_reg    <= state_next;
			pulse_reg    <= state_next == ST_PULSE; // R1
			chip_rst_reg <= state_next != ST_RUN; // R2
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			delay_reg <= DLY_W'(STARTUP_CYC - 1);
		end else if (state_reg != ST_DELAY) begin
			delay_reg <= DLY_W'(STARTUP_CYC - 1);
		end else begin
			delay_reg <= delay_reg - 1'b1; // R2
		end
	end

	// ------------------------------------------------------------
	// watchdog counter
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wcnt_reg <= '0;
		end else if (wcnt_clr || expire) begin
			wcnt_reg <= '0; // R4
		end else if (tick) begin
			wcnt_reg <= wcnt_reg + 1'b1; // R3
		end
	end

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= wdrs_ctrl_t'(RST_CTRL);
		end else if (in_reset) begin
			ctrl_reg <= wdrs_ctrl_t'(RST_CTRL);
		end else begin
			if (wr_ctrl) begin
				ctrl_reg.wdog_enable_bit <= en_write; // R8 R9
				ctrl_reg.wdog_period_sel <= wd_ctrl.wdog_period_sel;
			end
			if (toe_set) begin
				ctrl_reg.wdog_turnoff_enable <= 1'b1;
			end else if (toe_end) begin
				ctrl_reg.wdog_turnoff_enable <= 1'b0; // R7
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || in_reset) begin
			toe_cnt_reg <= 3'h0;
		end else if (toe_set) begin
			toe_cnt_reg <= TOE_CYC; // R7
		end else if (toe_cnt_reg != 3'h0) begin
			toe_cnt_reg <= toe_cnt_reg - 1'b1;
		end
	end

	// ------------------------------------------------------------
	// reset-cause flags
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cause_reg <= RST_CAUSE;
		end else begin
			cause_reg <= cause_next; // R12 R13 R14 R15 R16
		end
	end

	// ------------------------------------------------------------
	// interrupt
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_reg <= RST_IRQ;
			irq_en_reg   <= RST_IRQ;
			irq_reg      <= 1'b0;
		end else begin
			irq_stat_reg <= istat_nx;
			irq_en_reg   <= ien_nx;
			irq_reg      <= |(istat_nx & ien_nx);
		end
	end

	// ------------------------------------------------------------
	// axi write channels
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b1;
			aw_hold_reg <= 1'b0;
			awaddr_reg  <= '0;
		end else begin
			if (aw_fire) begin
				awready_reg <= 1'b0;
				aw_hold_reg <= 1'b1;
				awaddr_reg  <= awaddr;
			end else if (wr_go) begin
				aw_hold_reg <= 1'b0;
			end else if (b_fire) begin
				awready_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready_reg <= 1'b1;
			w_hold_reg <= 1'b0;
			wdata_reg  <= 32'h0;
			wstrb_reg  <= 4'h0;
		end else begin
			if (w_fire) begin
				wready_reg <= 1'b0;
				w_hold_reg <= 1'b1;
				wdata_reg  <= wdata;
				wstrb_reg  <= wstrb;
			end else if (wr_go) begin
				w_hold_reg <= 1'b0;
			end else if (b_fire) begin
				wready_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (b_fire) begin
			bvalid_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// axi read channels
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0;
			rresp_reg   <= RESP_OKAY;
		end else if (ar_fire) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b1;
			rdata_reg   <= rd_data;
			rresp_reg   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (r_fire) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign awready          = awready_reg;
	assign wready           = wready_reg;
	assign bvalid           = bvalid_reg;
	assign bresp            = bresp_reg;
	assign arready          = arready_reg;
	assign rvalid           = rvalid_reg;
	assign rdata            = rdata_reg;
	assign rresp            = rresp_reg;
	assign wdog_reset_pulse = pulse_reg;
	assign chip_reset       = chip_rst_reg;
	assign irq              = irq_reg;
endmodule

// ---- wdrs_checker.sv ----
// Purpose: port assertions for the watchdog and reset-cause block
// Assumes: one aclk domain, aresetn synchronous active low
// Notes:   delay length is measured with a helper counter
`timescale 1ns/1ps
module wdrs_checker
	import wdrs_pkg::*;
#(
	parameter int STARTUP_CYC = STARTUP_DELAY_CYC
) (
	// clock and reset
	input logic              aclk,
	input logic              aresetn,
	// register bus
	input logic              arvalid,
	input logic              arready,
	input logic [ADDR_W-1:0] araddr,
	input logic              rvalid,
	input logic [31:0]       rdata,
	input logic [1:0]        rresp,
	input logic              bvalid,
	input logic              awready,
	input logic              wready,
	// watchdog and resets
	input logic              wdog_restart,
	input wdrs_src_t         reset_src,
	input logic              wdog_reset_pulse,
	input logic              chip_reset
);
	// ------------------------------------------------------------
	// helpers and properties
	// ------------------------------------------------------------
	logic [ADDR_W-1:0] ar_q;
	logic              src_seen;
	int                hold_cnt;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ar_q <= '0;
			src_seen <= 1'b0;
			hold_cnt <= 0;
		end else begin
			if (arvalid && arready) begin
				ar_q <= araddr;
			end
			if (reset_src != 4'h0) begin
				src_seen <= 1'b1;
			end else if (wdog_reset_pulse) begin
				src_seen <= 1'b0;
			end
			if (wdog_reset_pulse) begin
				hold_cnt <= 1;
			end else if (chip_reset) begin
				hold_cnt <= hold_cnt + 1;
			end
		end
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_pulse;
		wdog_reset_pulse ##1 !wdog_reset_pulse;
	endsequence
	sequence s_src_reset;
		##[1:6] chip_reset;
	endsequence
	AST_PULSE_ONE: assert property ($rose(wdog_reset_pulse) |-> s_pulse)
		else $error("reset pulse not one cycle long");
	AST_PULSE_CHIP: assert property (wdog_reset_pulse |-> chip_reset)
		else $error("reset pulse without internal reset");
	AST_DELAY_LEN: assert property ($fell(chip_reset) && !src_seen
		|-> hold_cnt == STARTUP_CYC + 1)
		else $error("internal reset length wrong after expiry");
	AST_SRC_HOLD: assert property (reset_src != 4'h0 |-> s_src_reset)
		else $error("reset source did not hold internal reset");
	AST_CTRL_RSVD: assert property (rvalid && ar_q[7:2] == 6'h01
		|-> rdata[31:5] == 27'h0)
		else $error("control reserved bits read nonzero");
	AST_COUNT_ZERO: assert property ($rose(rvalid)
		&& ar_q[7:2] == 6'h05 && $past(wdog_restart, 2)
		&& $past(wdog_restart, 3) |-> rdata == 32'h0)
		else $error("counter not zero under restart");
	AST_UNMAPPED: assert property (rvalid && ar_q[7:2] > 6'h05
		|-> rresp == RESP_SLVERR && rdata == 32'h0)
		else $error("unmapped read not refused");
	AST_B_READY: assert property ($rose(bvalid) |-> !awready && !wready)
		else $error("write channels ready during response");
	AST_R_READY: assert property ($rose(rvalid) |-> !arready)
		else $error("read address ready during response");
endmodule
bind wdrs_top wdrs_checker #(.STARTUP_CYC(STARTUP_CYC)) i_wdrs_checker (
	.aclk(aclk), .aresetn(aresetn), .arvalid(arvalid), .arready(arready),
	.araddr(araddr), .rvalid(rvalid), .rdata(rdata), .rresp(rresp),
	.bvalid(bvalid), .awready(awready), .wready(wready),
	.wdog_restart(wdog_restart), .reset_src(reset_src),
	.wdog_reset_pulse(wdog_reset_pulse), .chip_reset(chip_reset)
);

// ---- wdrs_src_model.sv ----
// Purpose: oscillator and reset sources seen by the block
// Assumes: oscillator free running, unrelated in phase to aclk
// Notes:   sources follow the bench requests as levels
`timescale 1ns/1ps
module wdrs_src_model
	import wdrs_pkg::*;
(
	// requests from the bench
	input  wdrs_src_t src_req,
	// outputs to the block
	output logic      wdog_osc,
	output wdrs_src_t reset_src
);
	// ------------------------------------------------------------
	// oscillator at 1 MHz
	// ------------------------------------------------------------
	initial begin
		wdog_osc = 1'b0;
		#137;
		forever #500 wdog_osc = ~wdog_osc;
	end
	assign reset_src = src_req;
endmodule

// ---- wdrs_top_bench.sv ----
// Purpose: self-checking bench for the watchdog and reset-cause block
// Assumes: short timeout base and startup delay parameters
// Notes:   bready and rready are held high throughout
`timescale 1ns/1ps
module wdrs_top_bench;
	import wdrs_pkg::*;
	localparam int TB_BASE = 4;
	logic              aclk, aresetn, awvalid, awready, wvalid, wready;
	logic              bvalid, bready, arvalid, arready, rvalid, rready;
	logic              wdog_restart, wdog_osc, wdog_reset_pulse;
	logic              chip_reset, irq;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0]       wdata, rdata, rd_v;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp, rs;
	wdrs_src_t         reset_src, src_req;
	int                n_fail, cmp_count, cyc, osc_cnt, st;
	logic [7:0]        ofs [6] = '{OFS_CAUSE, OFS_CTRL, OFS_IRQ_STAT,
		OFS_IRQ_CLR, OFS_IRQ_EN, OFS_COUNT};
	logic [31:0]       rv [6] = '{{24'h0, RST_CAUSE}, {24'h0, RST_CTRL},
		32'h0, 32'h0, 32'h0, 32'h0};
	logic [31:0]       src_exp [4] = '{32'h10, 32'h14, 32'h16, 32'h01};
	wdrs_top #(.TIMEOUT_BASE(TB_BASE), .STARTUP_CYC(4)) i_wdrs_top (
		.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .wvalid(wvalid),
		.wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .rvalid(rvalid),
		.rready(rready), .rdata(rdata), .rresp(rresp),
		.wdog_restart(wdog_restart), .wdog_osc(wdog_osc),
		.reset_src(reset_src), .wdog_reset_pulse(wdog_reset_pulse),
		.chip_reset(chip_reset), .irq(irq));
	wdrs_src_model i_wdrs_src_model (.src_req(src_req),
		.wdog_osc(wdog_osc), .reset_src(reset_src));
	// ------------------------------------------------------------
	// clock, timeout and tasks
	// ------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	always @(posedge wdog_osc) osc_cnt <= osc_cnt + 1;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_fail++;
			conclude();
		end
	end
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, e);
		cmp_count++;
		if (s !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (awready === 1'b1 && !ad) begin
				awvalid <= 1'b0;
				ad = 1'b1;
			end
			if (wready === 1'b1 && !wd) begin
				wvalid <= 1'b0;
				wd = 1'b1;
			end
		end
		@(posedge aclk);
		while (bvalid !== 1'b1) @(posedge aclk);
		r = bresp;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		@(posedge aclk);
		while (arready !== 1'b1) @(posedge aclk);
		arvalid <= 1'b0;
		@(posedge aclk);
		while (rvalid !== 1'b1) @(posedge aclk);
		d = rdata;
		r = rresp;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e,
		input string n);
		rd(a, rd_v, rs);
		chk(n, rd_v, e);
	endtask
	task automatic expire(input logic [2:0] s);
		wdog_restart <= 1'b1;
		while (chip_reset !== 1'b0) @(posedge aclk);
		wr(OFS_CTRL, {28'h0, 1'b1, s}, rs);
		@(posedge wdog_osc);
		@(posedge aclk);
		wdog_restart <= 1'b0;
		st = osc_cnt;
		while (wdog_reset_pulse !== 1'b1) @(posedge aclk);
		chk("ticks", 32'(osc_cnt - st + 1), 32'(TB_BASE << s));
	endtask
	task automatic irq_is(input logic e);
		repeat (2) @(posedge aclk);
		chk("irq", {31'h0, irq}, {31'h0, e});
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{aresetn, awvalid, wvalid, arvalid, wdog_restart} = 5'h0;
		{bready, rready, wstrb} = 6'h3f;
		{awaddr, araddr, wdata, src_req} = '0;
		{n_fail, cmp_count, cyc, osc_cnt} = '0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 6; i++) rdc(ofs[i], rv[i], "reset");
		rd(8'h40, rd_v, rs);
		chk("unmapped read", {30'h0, rs}, {30'h0, RESP_SLVERR});
		wr(8'h40, 32'h1, rs);
		chk("unmapped write", {30'h0, rs}, {30'h0, RESP_SLVERR});
		wr(OFS_IRQ_STAT, 32'h3, rs);
		rdc(OFS_IRQ_STAT, 32'h0, "status ro");
		wr(OFS_CAUSE, 32'hff, rs);
		rdc(OFS_CAUSE, 32'h01, "cause kept");
		wr(OFS_CAUSE, 32'h00, rs);
		rdc(OFS_CAUSE, 32'h00, "cause cleared");
		$display("test registers done");
		wr(OFS_IRQ_EN, 32'h1, rs);
		for (int s = 0; s < 8; s++) begin
			expire(3'(s));
			if (s == 0) begin
				rdc(OFS_CAUSE, 32'h08, "wdog flag");
				irq_is(1'b1);
				wr(OFS_IRQ_EN, 32'h0, rs);
				irq_is(1'b0);
				wr(OFS_IRQ_EN, 32'h1, rs);
				irq_is(1'b1);
				wr(OFS_IRQ_CLR, 32'h1, rs);
				irq_is(1'b0);
			end
		end
		$display("test periods done");
		while (chip_reset !== 1'b0) @(posedge aclk);
		wdog_restart <= 1'b1;
		wr(OFS_CTRL, 32'hef, rs);
		rdc(OFS_CTRL, 32'h0f, "ctrl reserved");
		rdc(OFS_COUNT, 32'h0, "count restart");
		wr(OFS_CTRL, 32'h07, rs);
		rdc(OFS_CTRL, 32'h0f, "disable refused");
		wr(OFS_CTRL, 32'h1f, rs);
		repeat (8) @(posedge aclk);
		wr(OFS_CTRL, 32'h07, rs);
		rdc(OFS_CTRL, 32'h0f, "turnoff lapsed");
		wr(OFS_CTRL, 32'h1f, rs);
		wr(OFS_CTRL, 32'h07, rs);
		rdc(OFS_CTRL, 32'h07, "disabled");
		rdc(OFS_IRQ_STAT, 32'h03, "status");
		wdog_restart <= 1'b0;
		repeat (100) @(posedge aclk);
		rdc(OFS_COUNT, 32'h0, "count disabled");
		$display("test turnoff done");
		wr(OFS_CAUSE, 32'h00, rs);
		for (int i = 3; i >= 0; i--) begin
			src_req <= wdrs_src_t'(4'h1 << i);
			repeat (10) @(posedge aclk);
			src_req <= '0;
			repeat (4) @(posedge aclk);
			while (chip_reset !== 1'b0) @(posedge aclk);
			rdc(OFS_CAUSE, src_exp[3-i], "cause");
		end
		$display("test sources done");
		conclude();
	end
endmodule
